/* File: rtl/parallel_config_load_port.sv */
/*
 * parallel configuration load port, device side: samples host pins, assembles
 * configuration words into a fifo and runs status, load-complete and init sequencing.
 * assumes host pins are asynchronous and the host clock is far slower than sys_clk_in.
 */
`timescale 1ns/10ps
// Notes on behaviour
// - ratio 1, 4 or 8 by options
// - narrow modes use only low data lines
// - request low drops load-complete within 600 ns
// - request low drops status within 600 ns
// - status stays low 268 to 1506 us
// - status released within 1506 us of request
// - internal oscillator: user mode 175-437 us later
// - user clock: 4 periods, then 8576 clocks
// - user mode flags high; request low restarts
module parallel_config_load_port #(
    parameter int unsigned STATUS_LOW_CYC_P = pcl_pkg::STATUS_LOW_CYC,
    parameter int unsigned STATUS_MAX_CYC_P = pcl_pkg::STATUS_MAX_CYC,
    parameter int unsigned INIT_OSC_CYC_P = pcl_pkg::INIT_OSC_CYC,
    parameter int unsigned USER_INIT_CLKS_P = pcl_pkg::USER_INIT_CLKS
) (
    input wire logic sys_clk_in, // 25 MHz system clock
    input wire logic reset_in, // synchronous reset, power-up
    input wire pcl_pkg::link_in_t link_in, // request_n, cfg_clock, data pins
    input wire pcl_pkg::straps_t straps_in, // width and option straps
    input wire logic [31:0] image_words_in, // words per image, same clock
    input wire logic status_n_in, // level of the status wire
    output logic status_n_out, // status drive value, always low
    output logic status_n_oe_out, // high while pulling status low
    output logic load_done_out, // load-complete flag
    output logic user_mode_out, // device in user mode
    output logic error_out, // word lost, fifo full
    input wire logic user_init_clock_in, // optional init clock pin
    output logic [31:0] word_data_out, // assembled configuration word
    output logic word_valid_out, // word available
    input wire logic word_ready_in // sink takes word
);
    import pcl_pkg::*;

    localparam int SYNC_W = 41;
    localparam int REQ_LAT_MAX = 12;

    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    link_in_t link_s;
    straps_t straps_s;
    logic status_s;
    logic uclk_s;
    logic cclk_prev_q;
    logic uclk_prev_q;
    logic cclk_rise;
    logic cclk_fall;
    logic uclk_rise;
    state_t st_q;
    state_t st_d;
    straps_t mode_q;
    logic [3:0] ratio_q;
    logic [3:0] phase_q;
    logic [1:0] lane_q;
    logic [1:0] lane_last;
    logic [31:0] word_q;
    logic [31:0] word_next;
    logic [31:0] words_q;
    logic [31:0] timer_q;
    logic [1:0] falls_q;
    logic [13:0] uclk_q;
    logic sample;
    logic word_end;
    logic last_word;
    logic uclk_go;
    logic fifo_in_ready;

    // two-flop synchroniser for every pin
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            sync1_q <= '1;
            sync2_q <= '1;
        end else begin
            sync1_q <= {link_in, status_n_in, user_init_clock_in, straps_in};
            sync2_q <= sync1_q;
        end
    end
    assign {link_s, status_s, uclk_s, straps_s} = sync2_q;

    // edge finders on the synchronised clocks
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            cclk_prev_q <= 1'b1;
            uclk_prev_q <= 1'b1;
        end else begin
            cclk_prev_q <= link_s.clk;
            uclk_prev_q <= uclk_s;
        end
    end
    assign cclk_rise = link_s.clk && !cclk_prev_q;
    assign cclk_fall = !link_s.clk && cclk_prev_q;
    assign uclk_rise = uclk_s && !uclk_prev_q;

    // sampling decisions
    assign lane_last = last_lane_of(mode_q.width);
    assign sample = (st_q == ST_LOAD) && cclk_rise && (phase_q == 4'h0);
    assign word_end = sample && (lane_q == lane_last);
    assign last_word = (words_q == image_words_in - 32'h1);
    assign uclk_go = (timer_q >= CD2CU_CYC);

    // lane merge, narrow modes read only the low lines
    always_comb begin
        word_next = word_q;
        case (mode_q.width)
            WIDTH_8: word_next[lane_q*8 +: 8] = link_s.data[7:0];
            WIDTH_16: word_next[lane_q[0]*16 +: 16] = link_s.data[15:0];
            default: word_next = link_s.data;
        endcase
    end

    // sequencer next state
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_STATUS_LOW: begin
                if (link_s.request_n && timer_q >= STATUS_LOW_CYC_P - 1) begin
                    st_d = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                if (status_s) begin
                    st_d = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (word_end) begin
                    if (!fifo_in_ready) begin
                        st_d = ST_ERROR;
                    end else if (last_word) begin
                        st_d = (ratio_q == RATIO_PLAIN) ? ST_DONE : ST_TRAIL;
                    end
                end
            end
            ST_TRAIL: begin
                if (cclk_rise && phase_q == ratio_q - 4'h1) begin
                    st_d = ST_DONE;
                end
            end
            ST_DONE: begin
                if (cclk_fall && falls_q == 2'h1) begin
                    st_d = mode_q.use_user ? ST_INIT_USR : ST_INIT_OSC;
                end
            end
            ST_INIT_OSC: begin
                if (timer_q >= INIT_OSC_CYC_P - 1) begin
                    st_d = ST_USER;
                end
            end
            ST_INIT_USR: begin
                if (uclk_go && uclk_rise && uclk_q == USER_INIT_CLKS_P - 1) begin
                    st_d = ST_USER;
                end
            end
            ST_USER: st_d = ST_USER;
            ST_ERROR: st_d = ST_ERROR;
            default: st_d = ST_STATUS_LOW;
        endcase
        if (!link_s.request_n) begin
            st_d = ST_STATUS_LOW;
        end
    end

    // state register
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            st_q <= ST_STATUS_LOW;
        end else begin
            st_q <= st_d;
        end
    end

    // state timer, restarted on each change and while request is low
    always_ff @(posedge sys_clk_in) begin
        if (reset_in || st_d != st_q || !link_s.request_n) begin
            timer_q <= '0;
        end else if (timer_q != 32'hFFFFFFFF) begin
            timer_q <= timer_q + 32'h1;
        end
    end

    // mode latched as loading begins
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            mode_q <= '0;
            ratio_q <= RATIO_PLAIN;
        end else if (st_q == ST_RELEASE && st_d == ST_LOAD) begin
            mode_q <= straps_s;
            ratio_q <= ratio_of(straps_s.decompress, straps_s.security);
        end
    end

    // phase within ratio, lane within word, word assembly
    always_ff @(posedge sys_clk_in) begin
        if (reset_in || st_q == ST_RELEASE) begin
            phase_q <= '0;
            lane_q <= '0;
            word_q <= '0;
            words_q <= '0;
        end else begin
            if (cclk_rise && (st_q == ST_LOAD || st_q == ST_TRAIL)) begin
                phase_q <= (phase_q == ratio_q - 4'h1) ? 4'h0 : phase_q + 4'h1;
            end
            if (sample) begin
                word_q <= word_next;
                lane_q <= (lane_q == lane_last) ? 2'h0 : lane_q + 2'h1;
            end
            if (word_end && fifo_in_ready) begin
                words_q <= words_q + 32'h1;
            end
        end
    end

    // falling edges after completion and user clock count
    always_ff @(posedge sys_clk_in) begin
        if (reset_in || st_q != st_d) begin
            falls_q <= '0;
            uclk_q <= '0;
        end else begin
            if (st_q == ST_DONE && cclk_fall) begin
                falls_q <= falls_q + 2'h1;
            end
            if (st_q == ST_INIT_USR && uclk_go && uclk_rise) begin
                uclk_q <= uclk_q + 14'h1;
            end
        end
    end

    // pin-side flags from flip-flops
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            status_n_oe_out <= 1'b1;
            load_done_out <= 1'b0;
            user_mode_out <= 1'b0;
            error_out <= 1'b0;
        end else begin
            status_n_oe_out <= (st_d == ST_STATUS_LOW) || (st_d == ST_ERROR);
            load_done_out <= (st_d == ST_DONE) || (st_d == ST_INIT_OSC)
                             || (st_d == ST_INIT_USR) || (st_d == ST_USER);
            user_mode_out <= (st_d == ST_USER);
            error_out <= (st_d == ST_ERROR);
        end
    end
    assign status_n_out = 1'b0;

    // word buffer toward the configuration sink
    pcl_word_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(sys_clk_in),
        .reset_in(reset_in),
        .in_data_in(word_next),
        .in_valid_in(word_end),
        .in_ready_out(fifo_in_ready),
        .out_data_out(word_data_out),
        .out_valid_out(word_valid_out),
        .out_ready_in(word_ready_in)
    );

    // helper counters for the checks below
    logic [31:0] rises_q;
    logic [31:0] low_cnt_q;
    logic [31:0] rel_cnt_q;
    logic [31:0] done_cnt_q;
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            rises_q <= '0;
            low_cnt_q <= '0;
            rel_cnt_q <= '0;
            done_cnt_q <= '0;
        end else begin
            rises_q <= (word_end || st_q != ST_LOAD) ? '0 : rises_q + 32'(cclk_rise);
            low_cnt_q <= status_n_oe_out ? low_cnt_q + 32'h1 : '0;
            rel_cnt_q <= (status_n_oe_out && link_s.request_n && !error_out)
                         ? rel_cnt_q + 32'h1 : '0;
            done_cnt_q <= load_done_out ? done_cnt_q + 32'h1 : '0;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);

    property p_ratio_32;
        word_end && words_q != 0 && mode_q.width == WIDTH_32
            |-> rises_q + 1 == (mode_q.decompress ? 8 : (mode_q.security ? 4 : 1));
    endproperty
    a_ratio_32: assert property (p_ratio_32)
        else $error("word taken at wrong clock-to-data ratio");

    property p_narrow_lanes;
        word_end && words_q != 0 && mode_q.width != WIDTH_32
            |-> rises_q + 1 == ratio_q * (lane_last + 1);
    endproperty
    a_narrow_lanes: assert property (p_narrow_lanes)
        else $error("narrow mode word not built from all lanes");

    property p_done_low;
        $fell(link_s.request_n) |-> ##[1:REQ_LAT_MAX] !load_done_out;
    endproperty
    a_done_low: assert property (p_done_low)
        else $error("load-complete not low after request");

    property p_status_low;
        $fell(link_s.request_n) |-> ##[1:REQ_LAT_MAX] status_n_oe_out;
    endproperty
    a_status_low: assert property (p_status_low)
        else $error("status not pulled low after request");

    property p_status_width;
        $fell(status_n_oe_out) |-> low_cnt_q >= STATUS_LOW_CYC_P - 1;
    endproperty
    a_status_width: assert property (p_status_width)
        else $error("status low pulse too short");

    property p_status_release;
        rel_cnt_q <= STATUS_MAX_CYC_P;
    endproperty
    a_status_release: assert property (p_status_release)
        else $error("status not released in time");

    property p_osc_init;
        $rose(user_mode_out) && !mode_q.use_user |-> done_cnt_q >= INIT_OSC_CYC_P;
    endproperty
    a_osc_init: assert property (p_osc_init)
        else $error("user mode too early on oscillator");

    property p_user_init;
        $rose(user_mode_out) && mode_q.use_user
            |-> $past(uclk_q) == USER_INIT_CLKS_P - 1 && $past(uclk_go);
    endproperty
    a_user_init: assert property (p_user_init)
        else $error("user mode without full user clock count");

    property p_user_flags;
        user_mode_out |-> load_done_out && !status_n_oe_out;
    endproperty
    a_user_flags: assert property (p_user_flags)
        else $error("user mode flags inconsistent");

    property p_reconfig;
        user_mode_out && !link_s.request_n |=> !user_mode_out ##1 status_n_oe_out;
    endproperty
    a_reconfig: assert property (p_reconfig)
        else $error("request low did not leave user mode");

    // main scenarios
    c_user_osc: cover property ($rose(user_mode_out) && !mode_q.use_user);
    c_user_clk: cover property ($rose(user_mode_out) && mode_q.use_user);
    c_trail: cover property (st_q == ST_TRAIL && st_d == ST_DONE);
    c_overflow: cover property ($rose(error_out));
endmodule : parallel_config_load_port

/* File: rtl/pcl_pkg.sv */
/*
 * shared constants, carriers and states of the parallel configuration load port.
 * assumes a 25 MHz system clock; every pin-side signal is synchronised inside the load port.
 */
package pcl_pkg;

    // system clock
    localparam int unsigned SYS_CLK_NS = 40;

    // request low to flags low, longest time
    localparam int unsigned REQ_TO_LOW_NS = 600;
    localparam int unsigned REQ_TO_LOW_CYC = REQ_TO_LOW_NS / SYS_CLK_NS;

    // status low pulse, least and longest
    localparam int unsigned STATUS_LOW_MIN_US = 268;
    localparam int unsigned STATUS_LOW_CYC = (STATUS_LOW_MIN_US * 1000 + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int unsigned STATUS_LOW_MAX_US = 1506;
    localparam int unsigned STATUS_MAX_CYC = (STATUS_LOW_MAX_US * 1000) / SYS_CLK_NS;

    // load complete to user mode on the internal oscillator
    localparam int unsigned INIT_MIN_US = 175;
    localparam int unsigned INIT_OSC_CYC = (INIT_MIN_US * 1000 + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int unsigned INIT_MAX_US = 437;
    localparam int unsigned INIT_MAX_CYC = (INIT_MAX_US * 1000) / SYS_CLK_NS;

    // user init clock: enable delay and cycle count
    localparam int unsigned CFG_CLK_MIN_PERIOD_NS = 10;
    localparam int unsigned CD2CU_PERIODS = 4;
    localparam int unsigned CD2CU_RAW = (CD2CU_PERIODS * CFG_CLK_MIN_PERIOD_NS + SYS_CLK_NS - 1)
                                        / SYS_CLK_NS;
    localparam int unsigned CD2CU_CYC = (CD2CU_RAW < 1) ? 1 : CD2CU_RAW;
    localparam int unsigned USER_INIT_CLKS = 8576;

    // data width selection codes
    localparam logic [1:0] WIDTH_8 = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_32 = 2'h2;

    // clock-to-data ratios
    localparam logic [3:0] RATIO_PLAIN = 4'h1;
    localparam logic [3:0] RATIO_SECURE = 4'h4;
    localparam logic [3:0] RATIO_DECOMP = 4'h8;

    // fifo shape
    localparam int unsigned WORD_W = 32;
    localparam int unsigned FIFO_DEPTH = 16;

    // host-driven link pins
    typedef struct packed {
        logic request_n;
        logic clk;
        logic [31:0] data;
    } link_in_t;

    // mode straps
    typedef struct packed {
        logic [1:0] width;
        logic decompress;
        logic security;
        logic use_user;
    } straps_t;

    typedef enum logic [8:0] {
        ST_STATUS_LOW = 9'h001,
        ST_RELEASE = 9'h002,
        ST_LOAD = 9'h004,
        ST_TRAIL = 9'h008,
        ST_DONE = 9'h010,
        ST_INIT_OSC = 9'h020,
        ST_INIT_USR = 9'h040,
        ST_USER = 9'h080,
        ST_ERROR = 9'h100
    } state_t;

    // ratio from decompression and security options
    function automatic logic [3:0] ratio_of(input logic decompress, input logic security);
        ratio_of = decompress ? RATIO_DECOMP : (security ? RATIO_SECURE : RATIO_PLAIN);
    endfunction : ratio_of

    // index of the last lane in a 32-bit word
    function automatic logic [1:0] last_lane_of(input logic [1:0] width);
        last_lane_of = (width == WIDTH_8) ? 2'h3 : ((width == WIDTH_16) ? 2'h1 : 2'h0);
    endfunction : last_lane_of

endpackage : pcl_pkg

/* File: rtl/pcl_word_fifo.sv */
/*
 * synchronous word fifo with valid/ready on both sides.
 * assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps
module pcl_word_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 16
) (
    input wire logic clk_in, // system clock
    input wire logic reset_in, // synchronous reset
    input wire logic [WIDTH-1:0] in_data_in, // word to store
    input wire logic in_valid_in, // word offered
    output logic in_ready_out, // room for a word
    output logic [WIDTH-1:0] out_data_out, // oldest word
    output logic out_valid_out, // a word is held
    input wire logic out_ready_in // sink takes the word
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    // honest full and empty from the fill count
    assign in_ready_out = (count_q != DEPTH[AW:0]);
    assign out_valid_out = (count_q != '0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem_q[rd_q];

    // storage
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_q] <= in_data_in;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
            end
            count_q <= count_q + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule : pcl_word_fifo

/* File: tb/cfg_host_model.sv */
/*
 * behavioural configuration host: request, cfg_clock, data lanes, init clock.
 * assumes it is stepped on falling edges of the system clock; status has a pull-up.
 */
`timescale 1ns/10ps
module cfg_host_model (
    input wire logic sys_clk_in, // system clock
    input wire logic status_wire_in, // level of the status wire
    output pcl_pkg::link_in_t link_out, // pins toward the device
    output logic user_init_clock_out // optional init clock
);
    import pcl_pkg::*;
    // idle pins: request high, clock parked low
    initial begin
        link_out = '{request_n: 1'b1, clk: 1'b0, data: 32'h0};
        user_init_clock_out = 1'b0;
    end
    // wait n falling system clock edges
    task automatic wait_n(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask : wait_n
    // one 320 ns cfg_clock cycle, parked low afterwards
    task automatic tick();
        link_out.clk = 1'b1;
        wait_n(4);
        link_out.clk = 1'b0;
        wait_n(4);
    endtask : tick
    // pull request low
    task automatic drop_request();
        link_out.request_n = 1'b0;
    endtask : drop_request
    // release request, wait for status high, then the start gap
    task automatic raise_request(output int rel_cyc);
        link_out.request_n = 1'b1;
        rel_cyc = 0;
        while (status_wire_in !== 1'b1 && rel_cyc < 2000) begin
            wait_n(1);
            rel_cyc++;
        end
        wait_n(50);
    endtask : raise_request
    // send n words, r cycles per lane; optionally keep back the final cycle
    task automatic send_image(input logic [1:0] width, input logic [3:0] r, input int n,
                              input logic [15:0] base, input bit hold_last);
        int lanes;
        logic [31:0] w;
        logic [31:0] noise;
        lanes = (width == WIDTH_8) ? 4 : ((width == WIDTH_16) ? 2 : 1);
        for (int k = 0; k < n; k++) begin
            w = {base, k[15:0]};
            for (int j = 0; j < lanes; j++) begin
                noise = ~w ^ j;
                // unused upper lines carry noise
                link_out.data = (width == WIDTH_8) ? {noise[31:8], w[8*j +: 8]} :
                    ((width == WIDTH_16) ? {noise[31:16], w[16*j +: 16]} : w);
                for (int c = 0; c < r; c++) begin
                    if (!(hold_last && k == n - 1 && j == lanes - 1 && c == r - 1)) begin
                        tick();
                    end
                end
            end
        end
        link_out.data = ~link_out.data; // stale lines do not keep the word
    endtask : send_image
    // n cycles of the user init clock
    task automatic user_clocks(input int n);
        repeat (n) begin
            user_init_clock_out = 1'b1;
            wait_n(4);
            user_init_clock_out = 1'b0;
            wait_n(4);
        end
    endtask : user_clocks
endmodule : cfg_host_model

/* File: tb/tb_top.sv */
/*
 * self-checking bench of the parallel configuration load port with a host model.
 * assumes shortened status, init and user clock counts set by parameters here.
 */
`timescale 1ns/10ps
`define CHECK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin bad_count++; \
    $display("BAD %s exp %0h got %0h", nm, (ex), (gt)); end end
module tb_top;
    import pcl_pkg::*;
    localparam int ST_LOW = 20;
    localparam int ST_MAX = 100;
    localparam int OSC = 10;
    localparam int UCLK = 5;
    logic sys_clk_in = 1'b0;
    logic reset_in;
    link_in_t link;
    straps_t straps;
    logic [31:0] image_words;
    logic status_wire;
    logic status_drv, status_oe, load_done, user_mode, error_flag, user_clk;
    logic [31:0] word_data;
    logic word_valid;
    logic sink_ready;
    logic [31:0] got_q[$];
    int bad_count = 0;
    int compares = 0;
    // clock and open-drain status wire with pull-up
    always #20 sys_clk_in = ~sys_clk_in;
    assign status_wire = !(status_oe === 1'b1 && status_drv === 1'b0);
    cfg_host_model host (.sys_clk_in(sys_clk_in), .status_wire_in(status_wire),
        .link_out(link), .user_init_clock_out(user_clk));
    parallel_config_load_port #(.STATUS_LOW_CYC_P(ST_LOW), .STATUS_MAX_CYC_P(ST_MAX),
        .INIT_OSC_CYC_P(OSC), .USER_INIT_CLKS_P(UCLK)) i_parallel_config_load_port (
        .sys_clk_in(sys_clk_in), .reset_in(reset_in), .link_in(link), .straps_in(straps),
        .image_words_in(image_words), .status_n_in(status_wire), .status_n_out(status_drv),
        .status_n_oe_out(status_oe), .load_done_out(load_done), .user_mode_out(user_mode),
        .error_out(error_flag), .user_init_clock_in(user_clk), .word_data_out(word_data),
        .word_valid_out(word_valid), .word_ready_in(sink_ready));
    // sink side: record every word taken
    always @(posedge sys_clk_in) begin
        if (word_valid === 1'b1 && sink_ready === 1'b1) got_q.push_back(word_data);
    end
    // verdict and end of run
    task automatic complete_run();
        $display("counts: %0d compares, %0d bad", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    // request cycle with flag and status timing checks
    task automatic reconfig(input straps_t s, input int n);
        int rel;
        straps = s;
        image_words = n;
        got_q.delete();
        host.drop_request();
        host.wait_n(15);
        `CHECK("load_done", 1'b0, load_done)
        `CHECK("status_oe", 1'b1, status_oe)
        `CHECK("user_mode", 1'b0, user_mode)
        host.wait_n(35);
        host.raise_request(rel);
        `CHECK("status_min", 1'b1, rel >= ST_LOW)
        `CHECK("status_max", 1'b1, rel <= ST_MAX)
        `CHECK("error", 1'b0, error_flag)
    endtask : reconfig
    // whole load, trailing cycles and word contents
    task automatic load(input straps_t s, input logic [3:0] r, input int n,
                        input logic [15:0] base);
        reconfig(s, n);
        host.send_image(s.width, r, n, base, r > 1);
        if (r > 1) begin
            host.wait_n(20);
            `CHECK("done_early", 1'b0, load_done)
            host.tick();
        end
        host.wait_n(10);
        `CHECK("load_done", 1'b1, load_done)
        `CHECK("word_count", n, got_q.size())
        for (int k = 0; k < n && k < got_q.size(); k++) begin
            `CHECK("word", {base, k[15:0]}, got_q[k])
        end
        host.tick();
        host.tick();
        `CHECK("user_early", 1'b0, user_mode)
    endtask : load
    // flags in user mode
    task automatic user_flags();
        `CHECK("user_mode", 1'b1, user_mode)
        `CHECK("status_high", 1'b1, status_wire)
        `CHECK("done_high", 1'b1, load_done)
    endtask : user_flags
    // reset values and power-up status pulse
    task automatic t_reset();
        int rel;
        `CHECK("rst_oe", 1'b1, status_oe)
        `CHECK("rst_done", 1'b0, load_done)
        `CHECK("rst_valid", 1'b0, word_valid)
        `CHECK("rst_error", 1'b0, error_flag)
        reset_in = 1'b0;
        rel = 0;
        while (status_wire !== 1'b1 && rel < 2000) begin
            host.wait_n(1);
            rel++;
        end
        `CHECK("por_min", 1'b1, rel >= ST_LOW)
        `CHECK("por_max", 1'b1, rel <= ST_MAX)
        $display("test reset done");
    endtask : t_reset
    // 32-bit plain load, oscillator init
    task automatic t_plain32();
        load('{width: WIDTH_32, decompress: 1'b0, security: 1'b0, use_user: 1'b0},
             RATIO_PLAIN, 3, 16'hC3A0);
        host.wait_n(OSC + 10);
        user_flags();
        $display("test plain32 done");
    endtask : t_plain32
    // 8-bit secure load, user init clock count
    task automatic t_secure8_user();
        load('{width: WIDTH_8, decompress: 1'b0, security: 1'b1, use_user: 1'b1},
             RATIO_SECURE, 2, 16'h5A17);
        host.user_clocks(UCLK - 1);
        host.wait_n(OSC + 10);
        `CHECK("user_wait", 1'b0, user_mode)
        host.user_clocks(1);
        host.wait_n(10);
        user_flags();
        $display("test secure8_user done");
    endtask : t_secure8_user
    // 16-bit loads with decompression, with and without security
    task automatic t_decomp16();
        load('{width: WIDTH_16, decompress: 1'b1, security: 1'b1, use_user: 1'b0},
             RATIO_DECOMP, 2, 16'h96E1);
        host.wait_n(OSC + 10);
        user_flags();
        load('{width: WIDTH_16, decompress: 1'b1, security: 1'b0, use_user: 1'b0},
             RATIO_DECOMP, 1, 16'h3C4D);
        host.wait_n(OSC + 10);
        user_flags();
        $display("test decomp16 done");
    endtask : t_decomp16
    // stalled sink: fifo fills, refuses, then drains empty
    task automatic t_overflow();
        straps_t s;
        s = '{width: WIDTH_32, decompress: 1'b0, security: 1'b0, use_user: 1'b0};
        sink_ready = 1'b0;
        reconfig(s, FIFO_DEPTH + 1);
        host.send_image(WIDTH_32, RATIO_PLAIN, FIFO_DEPTH + 1, 16'h7E00, 1'b0);
        host.wait_n(10);
        `CHECK("error", 1'b1, error_flag)
        `CHECK("err_status", 1'b1, status_oe)
        `CHECK("err_done", 1'b0, load_done)
        sink_ready = 1'b1;
        host.wait_n(30);
        `CHECK("drained", FIFO_DEPTH, got_q.size())
        `CHECK("empty", 1'b0, word_valid)
        load(s, RATIO_PLAIN, 1, 16'h0F0F);
        host.wait_n(OSC + 10);
        user_flags();
        $display("test overflow done");
    endtask : t_overflow
    // main sequence: reset held 4 cycles
    initial begin
        reset_in = 1'b1;
        straps = '{width: WIDTH_32, decompress: 1'b0, security: 1'b0, use_user: 1'b0};
        image_words = 32'h1;
        sink_ready = 1'b1;
        host.wait_n(4);
        t_reset();
        t_plain32();
        t_secure8_user();
        t_decomp16();
        t_overflow();
        complete_run();
    end
    // watchdog
    initial begin
        #(20000 * 40);
        bad_count++;
        complete_run();
    end
endmodule : tb_top
